//--- frame_filter_pkg.sv
// Constants, field layouts and state codes for the receive acceptance and
// transmit interrupt configuration block.
// Assumes a 100 MHz clock and a 10 Mb/s line (one bit time is 100 ns).
package frame_filter_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [9:0] RX_CTL_INDEX = 10'h104;
  localparam logic [9:0] TX_CFG_INDEX = 10'h106;
  localparam int ADDR_WIDTH = 12;

  // Reset values and the identification patterns in bits 5:0
  localparam logic [15:0] RX_CTL_RESET = 16'h0005;
  localparam logic [15:0] TX_CFG_RESET = 16'h0007;
  // Bits software may change; everything else is fixed
  localparam logic [15:0] RX_CTL_WRITABLE = 16'h7fc0;
  localparam logic [15:0] TX_CFG_WRITABLE = 16'h8fc0;

  // Receive control field positions
  localparam int ACCEPT_HASHED_UNICAST = 6;
  localparam int ACCEPT_ANY_ADDRESS = 7;
  localparam int ACCEPT_GOOD_FRAMES = 8;
  localparam int ACCEPT_HASHED_GROUP = 9;
  localparam int ACCEPT_STATION_ADDRESS = 10;
  localparam int ACCEPT_ALL_ONES_ADDRESS = 11;
  localparam int ACCEPT_BAD_CHECKSUM = 12;
  localparam int ACCEPT_SHORT_FRAMES = 13;
  localparam int ACCEPT_OVERLONG_FRAMES = 14;

  // Transmit interrupt enable positions
  localparam int CARRIER_LOSS_IRQ_EN = 6;
  localparam int HEARTBEAT_MISSING_IRQ_EN = 7;
  localparam int TX_DONE_IRQ_EN = 8;
  localparam int LATE_COLLISION_IRQ_EN = 9;
  localparam int OVERLONG_TX_IRQ_EN = 10;
  localparam int ANY_COLLISION_IRQ_EN = 11;
  localparam int EXCESS_COLLISION_IRQ_EN = 15;

  // Frame length limits in bytes
  localparam logic [15:0] MIN_KEPT_LENGTH = 16'h0008;
  localparam logic [15:0] MIN_VALID_LENGTH = 16'h0040;
  localparam logic [15:0] MAX_VALID_LENGTH = 16'h05ee;

  // Timing
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int BIT_TIME_NS = 100;
  localparam int SQE_WINDOW_BITS = 64;
  localparam int LATE_WINDOW_BITS = 512;
  localparam int JABBER_LIMIT_MS = 26;
  localparam int SQE_WINDOW_CYCLES = SQE_WINDOW_BITS * BIT_TIME_NS / CLOCK_PERIOD_NS;
  localparam int LATE_WINDOW_CYCLES = LATE_WINDOW_BITS * BIT_TIME_NS / CLOCK_PERIOD_NS;
  localparam int JABBER_LIMIT_CYCLES = JABBER_LIMIT_MS * 1000000 / CLOCK_PERIOD_NS;
  localparam int TIMER_WIDTH = 22;
  localparam logic [4:0] COLLISION_LIMIT = 5'h10;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_SEND = 3'h2,
    TX_SQE_WAIT = 3'h4
  } tx_state_t;

endpackage

//--- frame_filter.sv
// Receive frame acceptance control and transmit interrupt configuration,
// with an AXI4-Lite register slave, the frame accept decision and the
// transmit event tracker that raises interrupts.
// Assumes the MAC datapath supplies per-frame and per-transmission event
// pulses synchronous to clock, and that the hash filter result comes ready.
//
// Function
// - Low six bits read fixed 000101 and 000111 as register identifiers.
// - Accept a frame only when its destination passes an enabled address filter.
// - Bit 6 accepts unicast destinations that hit the hash filter.
// - Bit 7 accepts any destination address.
// - Bit 8 accepts good-checksum frames of 64 to 1518 bytes.
// - Bit 9 accepts multicast destinations that hit the hash filter.
// - Bit A accepts destinations equal to the station address.
// - Bit B accepts the all-ones broadcast destination.
// - Bit C accepts address-matching bad-checksum frames; otherwise they are discarded.
// - Bit D accepts address-matching frames under 64 bytes; otherwise discarded.
// - Frames under 8 bytes are always discarded.
// - Bit E keeps first 1518 bytes of overlong frames; otherwise discarded.
// - Receive control resets to 0x0005 unless an EEPROM supplies a value.
// - Bit 6 interrupts when AUI carrier is missing at preamble end.
// - Bit 7 interrupts when no collision follows AUI transmit within 64 bits.
// - Bit 8 interrupts on each completely transmitted packet.
// - Late collision forces bad checksum, ends transmit; bit 9 interrupts.
// - Bit A interrupts when a transmission exceeds about 26 ms.
// - Bit B interrupts once at packet end if any collision occurred.
// - Sixteen collisions abandon the packet; bit F interrupts on the sixteenth.
// - Transmit configuration resets to 0x0007, all enables clear, unless EEPROM.
//
// Local design decision: the AXI4-Lite register port.
module frame_filter
  import frame_filter_pkg::*;
#(
  parameter logic [TIMER_WIDTH-1:0] LATE_WINDOW = TIMER_WIDTH'(LATE_WINDOW_CYCLES),
  parameter logic [TIMER_WIDTH-1:0] JABBER_LIMIT = TIMER_WIDTH'(JABBER_LIMIT_CYCLES)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [frame_filter_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [frame_filter_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // EEPROM-supplied initial values
  input wire logic eeprom_present,
  input wire logic eeprom_load,
  input wire logic [15:0] eeprom_rx_ctl,
  input wire logic [15:0] eeprom_tx_cfg,
  // Receive frame summary, valid with rx_frame_end
  input wire logic rx_frame_end,
  input wire logic [15:0] rx_length,
  input wire logic rx_crc_ok,
  input wire logic rx_dest_station,
  input wire logic rx_dest_group,
  input wire logic rx_dest_all_ones,
  input wire logic rx_hash_hit,
  output logic rx_accept,
  output logic rx_discard,
  output logic rx_truncate,
  // Transmit events
  input wire logic tx_start,
  input wire logic tx_on_aui,
  input wire logic tx_preamble_end,
  input wire logic carrier_sense,
  input wire logic tx_collision,
  input wire logic tx_last_bit,
  output logic tx_force_bad_crc,
  output logic tx_terminate,
  output logic tx_give_up,
  output logic tx_irq,
  output logic [15:0] receive_frame_accept_control,
  output logic [15:0] transmit_interrupt_config
);

  typedef struct packed {
    logic aw_held;
    logic [9:0] aw_index;
    logic w_held;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [15:0] rx_ctl;
    logic [15:0] tx_cfg;
    logic rx_accept;
    logic rx_discard;
    logic rx_truncate;
    tx_state_t tx_state;
    logic [TIMER_WIDTH-1:0] timer;
    logic [4:0] collisions;
    logic force_bad_crc;
    logic terminate;
    logic give_up;
    logic irq;
  } state_t;

  state_t st;
  state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [9:0] word_index(input logic [ADDR_WIDTH-1:0] addr);
    return addr[ADDR_WIDTH-1:2];
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] data,
                                        input logic [15:0] writable, input logic [1:0] strb);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & writable;
    return (old & ~lanes) | (data & lanes);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Frame acceptance

  logic addr_pass;
  logic is_short;
  logic is_long;
  logic frame_ok;

  always_comb begin
    addr_pass = 1'b0;
    if (st.rx_ctl[ACCEPT_ANY_ADDRESS]) begin
      addr_pass = 1'b1;
    end
    if (st.rx_ctl[ACCEPT_HASHED_UNICAST] && rx_hash_hit && !rx_dest_group) begin
      addr_pass = 1'b1;
    end
    if (st.rx_ctl[ACCEPT_HASHED_GROUP] && rx_hash_hit && rx_dest_group && !rx_dest_all_ones) begin
      addr_pass = 1'b1;
    end
    if (st.rx_ctl[ACCEPT_STATION_ADDRESS] && rx_dest_station) begin
      addr_pass = 1'b1;
    end
    if (st.rx_ctl[ACCEPT_ALL_ONES_ADDRESS] && rx_dest_all_ones) begin
      addr_pass = 1'b1;
    end
    is_short = rx_length < MIN_VALID_LENGTH;
    is_long = rx_length > MAX_VALID_LENGTH;
    frame_ok = addr_pass;
    if (rx_length < MIN_KEPT_LENGTH) begin
      frame_ok = 1'b0;
    end
    if (!rx_crc_ok && !st.rx_ctl[ACCEPT_BAD_CHECKSUM]) begin
      frame_ok = 1'b0;
    end
    if (is_short && !st.rx_ctl[ACCEPT_SHORT_FRAMES]) begin
      frame_ok = 1'b0;
    end
    if (is_long && !st.rx_ctl[ACCEPT_OVERLONG_FRAMES]) begin
      frame_ok = 1'b0;
    end
    if (rx_crc_ok && !is_short && !is_long && !st.rx_ctl[ACCEPT_GOOD_FRAMES]) begin
      frame_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic [15:0] read_value;

  // Readies drop while frozen, so no transfer is taken and then lost
  assign s_axi_awready = enable && !st.aw_held && !st.bvalid;
  assign s_axi_wready = enable && !st.w_held && !st.bvalid;
  assign s_axi_arready = enable && !st.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_comb begin
    next_st = st;
    next_st.rx_accept = 1'b0;
    next_st.rx_discard = 1'b0;
    next_st.rx_truncate = 1'b0;
    next_st.force_bad_crc = 1'b0;
    next_st.terminate = 1'b0;
    next_st.give_up = 1'b0;
    next_st.irq = 1'b0;
    read_value = 16'h0000;

    // Write channel: address and data arrive in either order
    if (aw_take) begin
      next_st.aw_held = 1'b1;
      next_st.aw_index = word_index(s_axi_awaddr);
    end
    if (w_take) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata[15:0];
      next_st.w_strb = s_axi_wstrb[1:0];
    end
    if (st.aw_held && st.w_held) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      if (st.aw_index == RX_CTL_INDEX) begin
        next_st.rx_ctl = merge(st.rx_ctl, st.w_data, RX_CTL_WRITABLE, st.w_strb);
      end else if (st.aw_index == TX_CFG_INDEX) begin
        next_st.tx_cfg = merge(st.tx_cfg, st.w_data, TX_CFG_WRITABLE, st.w_strb);
      end else begin
        next_st.bresp = RESP_DECERR;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // Read channel
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      if (word_index(s_axi_araddr) == RX_CTL_INDEX) begin
        read_value = st.rx_ctl;
      end else if (word_index(s_axi_araddr) == TX_CFG_INDEX) begin
        read_value = st.tx_cfg;
      end else begin
        next_st.rresp = RESP_DECERR;
      end
      next_st.rdata = read_value;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    if (eeprom_load && eeprom_present) begin
      next_st.rx_ctl = merge(RX_CTL_RESET, eeprom_rx_ctl, RX_CTL_WRITABLE, 2'h3);
      next_st.tx_cfg = merge(TX_CFG_RESET, eeprom_tx_cfg, TX_CFG_WRITABLE, 2'h3);
    end

    // Receive decision, one pulse per frame
    if (rx_frame_end) begin
      next_st.rx_accept = frame_ok;
      next_st.rx_discard = !frame_ok;
      next_st.rx_truncate = frame_ok && is_long;
    end

    if (tx_preamble_end && tx_on_aui && !carrier_sense && st.tx_cfg[CARRIER_LOSS_IRQ_EN]) begin
      next_st.irq = 1'b1;
    end

    case (st.tx_state)
      TX_IDLE: begin
        if (tx_start) begin
          next_st.tx_state = TX_SEND;
          next_st.timer = '0;
        end
      end
      TX_SEND: begin
        next_st.timer = st.timer + 1'b1;
        if (tx_collision) begin
          next_st.tx_state = TX_IDLE;
          if (st.timer >= LATE_WINDOW) begin
            next_st.force_bad_crc = 1'b1;
            next_st.terminate = 1'b1;
            next_st.collisions = '0;
            next_st.irq = next_st.irq | st.tx_cfg[LATE_COLLISION_IRQ_EN];
          end else if (st.collisions + 5'h01 == COLLISION_LIMIT) begin
            next_st.give_up = 1'b1;
            next_st.collisions = '0;
            next_st.irq = next_st.irq | st.tx_cfg[EXCESS_COLLISION_IRQ_EN];
          end else begin
            // Attempt ends; the datapath backs off and restarts the same packet
            next_st.collisions = st.collisions + 5'h01;
          end
        end else if (st.timer >= JABBER_LIMIT) begin
          next_st.tx_state = TX_IDLE;
          next_st.terminate = 1'b1;
          next_st.collisions = '0;
          next_st.irq = next_st.irq | st.tx_cfg[OVERLONG_TX_IRQ_EN];
        end else if (tx_last_bit) begin
          next_st.irq = next_st.irq | st.tx_cfg[TX_DONE_IRQ_EN];
          if (st.collisions != 5'h00 && st.tx_cfg[ANY_COLLISION_IRQ_EN]) begin
            next_st.irq = 1'b1;
          end
          next_st.collisions = '0;
          next_st.timer = '0;
          next_st.tx_state = tx_on_aui ? TX_SQE_WAIT : TX_IDLE;
        end
      end
      TX_SQE_WAIT: begin
        next_st.timer = st.timer + 1'b1;
        if (tx_collision) begin
          next_st.tx_state = TX_IDLE;
        end else if (st.timer == TIMER_WIDTH'(SQE_WINDOW_CYCLES - 1)) begin
          next_st.tx_state = TX_IDLE;
          next_st.irq = next_st.irq | st.tx_cfg[HEARTBEAT_MISSING_IRQ_EN];
        end
      end
      default: begin
        next_st.tx_state = TX_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '0;
      st.rx_ctl <= RX_CTL_RESET;
      st.tx_cfg <= TX_CFG_RESET;
      st.tx_state <= TX_IDLE;
    end else if (enable) begin
      st <= next_st;
    end
  end

  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = {16'h0000, st.rdata};
  assign s_axi_rresp = st.rresp;
  assign rx_accept = st.rx_accept;
  assign rx_discard = st.rx_discard;
  assign rx_truncate = st.rx_truncate;
  assign tx_force_bad_crc = st.force_bad_crc;
  assign tx_terminate = st.terminate;
  assign tx_give_up = st.give_up;
  assign tx_irq = st.irq;
  assign receive_frame_accept_control = st.rx_ctl;
  assign transmit_interrupt_config = st.tx_cfg;

endmodule

//--- frame_filter_assertions.sv
// Checker for the frame filter block, watching its ports only.
// Assumes one clock domain and synchronous reset; checks other than the freeze check pause while enable is low.
module frame_filter_assertions
  import frame_filter_pkg::*;
#(
  parameter logic [TIMER_WIDTH-1:0] LATE_WINDOW = TIMER_WIDTH'(LATE_WINDOW_CYCLES),
  parameter logic [TIMER_WIDTH-1:0] JABBER_LIMIT = TIMER_WIDTH'(JABBER_LIMIT_CYCLES)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic rx_frame_end,
  input wire logic [15:0] rx_length,
  input wire logic rx_crc_ok,
  input wire logic rx_accept,
  input wire logic rx_discard,
  input wire logic rx_truncate,
  input wire logic tx_collision,
  input wire logic tx_force_bad_crc,
  input wire logic tx_terminate,
  input wire logic [15:0] receive_frame_accept_control,
  input wire logic [15:0] transmit_interrupt_config
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !enable);
  ////////////////////////////////////////////////////////////////////////////
  id_bits_a: assert property (receive_frame_accept_control[5:0] == 6'h05 && transmit_interrupt_config[5:0] == 6'h07)
    else $error("identification bits wrong");
  undef_zero_a: assert property (!receive_frame_accept_control[15] && transmit_interrupt_config[14:12] == 3'h0)
    else $error("undefined bits not zero");
  reset_values_a: assert property ($past(rst) |-> receive_frame_accept_control == RX_CTL_RESET
    && transmit_interrupt_config == TX_CFG_RESET) else $error("register reset value wrong");
  one_answer_a: assert property (rx_frame_end |=> rx_accept != rx_discard)
    else $error("frame not answered once");
  short_drop_a: assert property (rx_frame_end && rx_length < MIN_KEPT_LENGTH |=> rx_discard)
    else $error("tiny frame kept");
  bad_crc_a: assert property (rx_frame_end && !rx_crc_ok && !receive_frame_accept_control[12] |=> rx_discard)
    else $error("bad checksum frame kept");
  trunc_accept_a: assert property (rx_truncate |-> rx_accept && $past(rx_length) > MAX_VALID_LENGTH)
    else $error("truncate without long accepted frame");
  late_crc_a: assert property (tx_force_bad_crc |-> tx_terminate && $past(tx_collision))
    else $error("bad checksum forcing without collision or end");
  freeze_a: assert property (disable iff (rst) !enable |=> $stable(receive_frame_accept_control)
    && $stable(transmit_interrupt_config)) else $error("registers changed while frozen");
endmodule
bind frame_filter frame_filter_assertions #(.LATE_WINDOW(LATE_WINDOW), .JABBER_LIMIT(JABBER_LIMIT)) chk_u (
  .clock, .rst, .enable, .rx_frame_end, .rx_length, .rx_crc_ok, .rx_accept, .rx_discard, .rx_truncate,
  .tx_collision, .tx_force_bad_crc, .tx_terminate, .receive_frame_accept_control, .transmit_interrupt_config);

//--- axi_host_model.sv
// Host processor model: an AXI4-Lite master with one write and one read task.
// Assumes the slave answers in its own time; the bench watchdog ends a hang.
module axi_host_model (
  input wire logic clock,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output logic [11:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Handshakes are judged before the edge so the design's own update cannot race
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clock);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge clock);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clock);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
endmodule

//--- testbench.sv
// Self-checking bench for the frame filter: register access, accept decisions, transmit interrupts.
// Assumes shortened late and jabber windows of 50 and 300 cycles.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import frame_filter_pkg::*;
  logic clock, rst, rx_frame_end, rx_crc_ok, rx_dest_station, rx_dest_group, rx_dest_all_ones, rx_hash_hit;
  logic rx_accept, rx_discard, rx_truncate, tx_start, tx_on_aui, tx_preamble_end, carrier_sense, tx_collision;
  logic tx_last_bit, tx_force_bad_crc, tx_terminate, tx_give_up, tx_irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] rx_length, receive_frame_accept_control, transmit_interrupt_config;
  logic enable, eeprom_present, eeprom_load;
  logic [15:0] eeprom_rx_ctl, eeprom_tx_cfg;
  logic [7:0] n_irq = 8'h00, n_term = 8'h00, n_give = 8'h00, n_bad = 8'h00;
  int mismatches = 0, n_compared = 0;
  typedef struct packed {logic [15:0] c; logic [15:0] l; logic [4:0] f; logic [1:0] e;} rx_row_t;
  // Flags are crc_ok, station, group, all_ones, hash; outcome is accept, truncate
  rx_row_t rows [17] = '{'{16'h0100, 16'h0064, 5'h10, 2'h0}, '{16'h0180, 16'h0064, 5'h10, 2'h2},
    '{16'h0080, 16'h0064, 5'h10, 2'h0}, '{16'h0140, 16'h0064, 5'h11, 2'h2}, '{16'h0140, 16'h0064, 5'h15, 2'h0},
    '{16'h0300, 16'h0064, 5'h15, 2'h2}, '{16'h0500, 16'h0064, 5'h18, 2'h2}, '{16'h0900, 16'h0064, 5'h16, 2'h2},
    '{16'h0180, 16'h0064, 5'h00, 2'h0}, '{16'h1080, 16'h0064, 5'h00, 2'h2}, '{16'h2080, 16'h003f, 5'h10, 2'h2},
    '{16'h0180, 16'h003f, 5'h10, 2'h0}, '{16'h2080, 16'h0007, 5'h10, 2'h0}, '{16'h4080, 16'h05ef, 5'h10, 2'h3},
    '{16'h0180, 16'h05ef, 5'h10, 2'h0}, '{16'h0180, 16'h05ee, 5'h10, 2'h2}, '{16'h0180, 16'h0040, 5'h10, 2'h2}};
  frame_filter #(.LATE_WINDOW(22'h0032), .JABBER_LIMIT(22'h012c)) dut_u (.clock, .rst, .enable,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .eeprom_present, .eeprom_load,
    .eeprom_rx_ctl, .eeprom_tx_cfg, .rx_frame_end, .rx_length, .rx_crc_ok, .rx_dest_station,
    .rx_dest_group, .rx_dest_all_ones, .rx_hash_hit, .rx_accept, .rx_discard, .rx_truncate, .tx_start, .tx_on_aui,
    .tx_preamble_end, .carrier_sense, .tx_collision, .tx_last_bit, .tx_force_bad_crc, .tx_terminate, .tx_give_up,
    .tx_irq, .receive_frame_accept_control, .transmit_interrupt_config);
  axi_host_model host_u (.clock, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    n_irq <= n_irq + tx_irq;
    n_term <= n_term + tx_terminate;
    n_give <= n_give + tx_give_up;
    n_bad <= n_bad + tx_force_bad_crc;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Kinds: 0 done, 1 collision then done, 2 late collision, 3 jabber, 4 sixteen collisions,
  // 5 heartbeat missing, 6 heartbeat seen, 7 carrier lost, 8 carrier present
  task automatic txrun(input logic [15:0] cfg, input int k, input logic [31:0] exp);
    logic [31:0] base;
    host_u.wr(12'h418, {16'h0000, cfg}, 4'hf, resp);
    base = {n_irq, n_term, n_give, n_bad};
    tx_on_aui <= (k >= 5);
    carrier_sense <= (k == 8);
    @(posedge clock);
    if (k < 7) begin
      for (int i = 0; i < (k == 4 ? 16 : k == 1 ? 2 : 1); i++) begin
        tx_start <= 1'b1;
        @(posedge clock);
        tx_start <= 1'b0;
        repeat (k == 2 ? 60 : k == 3 ? 320 : 3) @(posedge clock);
        tx_collision <= (k == 2 || k == 4 || (k == 1 && i == 0));
        tx_last_bit <= (k == 0 || k >= 5 || (k == 1 && i == 1));
        @(posedge clock);
        tx_collision <= 1'b0;
        tx_last_bit <= 1'b0;
        repeat (3) @(posedge clock);
      end
      tx_collision <= (k == 6);
    end else tx_preamble_end <= 1'b1;
    @(posedge clock);
    {tx_collision, tx_preamble_end} <= 2'h0;
    repeat (700) @(posedge clock);
    tx_on_aui <= 1'b0;
    chk({n_irq, n_term, n_give, n_bad} - base, exp);
  endtask
  initial begin
    #300us;
    mismatches++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {rx_frame_end, rx_crc_ok, rx_dest_station, rx_dest_group, rx_dest_all_ones, rx_hash_hit} = 6'h00;
    {tx_start, tx_on_aui, tx_preamble_end, carrier_sense, tx_collision, tx_last_bit} = 6'h00;
    rx_length = 16'h0000;
    {enable, eeprom_present, eeprom_load} = 3'h4;
    {eeprom_rx_ctl, eeprom_tx_cfg} = 32'h0000_0000;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    host_u.rd(12'h410, rdat, resp);
    chk(rdat, 32'h0000_0005);
    host_u.rd(12'h418, rdat, resp);
    chk({resp, rdat[29:0]}, {RESP_OKAY, 30'h0000_0007});
    // error interrupt enables for discarded frames sit outside this block
    foreach (rows[i]) begin
      host_u.wr(12'h410, {16'h0000, rows[i].c}, 4'hf, resp);
      rx_frame_end <= 1'b1;
      rx_length <= rows[i].l;
      {rx_crc_ok, rx_dest_station, rx_dest_group, rx_dest_all_ones, rx_hash_hit} <= rows[i].f;
      @(posedge clock);
      rx_frame_end <= 1'b0;
      @(negedge clock);
      chk({rx_accept, rx_truncate, rx_discard}, {rows[i].e, ~rows[i].e[1]});
    end
    host_u.wr(12'h410, 32'hffff_ffff, 4'hf, resp);
    host_u.rd(12'h410, rdat, resp);
    chk(rdat, 32'h0000_7fc5);
    host_u.wr(12'h418, 32'hffff_ffff, 4'hf, resp);
    host_u.rd(12'h418, rdat, resp);
    chk(rdat, 32'h0000_8fc7);
    host_u.wr(12'h418, 32'h0000_0000, 4'h2, resp);
    chk(transmit_interrupt_config, 32'h0000_00c7);
    host_u.wr(12'h400, 32'hffff_ffff, 4'hf, resp);
    chk(resp, RESP_DECERR);
    host_u.rd(12'h400, rdat, resp);
    chk({resp, rdat[29:0]}, {RESP_DECERR, 30'h0000_0000});
    txrun(16'h0100, 0, 32'h0100_0000);
    txrun(16'h0000, 0, 32'h0000_0000);
    txrun(16'h0800, 1, 32'h0100_0000);
    txrun(16'h0800, 0, 32'h0000_0000);
    txrun(16'h0200, 2, 32'h0101_0001);
    txrun(16'h0000, 2, 32'h0001_0001);
    txrun(16'h0400, 3, 32'h0101_0000);
    txrun(16'h8000, 4, 32'h0100_0100);
    txrun(16'h0080, 5, 32'h0100_0000);
    txrun(16'h0080, 6, 32'h0000_0000);
    txrun(16'h0040, 7, 32'h0100_0000);
    txrun(16'h0040, 8, 32'h0000_0000);
    // A second reset in mid-run must restore both registers
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    host_u.rd(12'h410, rdat, resp);
    chk(rdat, 32'h0000_0005);
    chk(transmit_interrupt_config, 32'h0000_0007);
    // EEPROM values count only while one is present
    eeprom_rx_ctl <= 16'h0a5a;
    eeprom_tx_cfg <= 16'hf0ff;
    for (int p = 0; p < 2; p++) begin
      @(posedge clock);
      eeprom_present <= p[0];
      eeprom_load <= 1'b1;
      @(posedge clock);
      eeprom_load <= 1'b0;
      @(negedge clock);
      chk(receive_frame_accept_control, p ? 32'h0000_0a45 : 32'h0000_0005);
      chk(transmit_interrupt_config, p ? 32'h0000_80c7 : 32'h0000_0007);
    end
    // Low enable refuses the bus and freezes the registers against a load
    @(posedge clock);
    enable <= 1'b0;
    eeprom_load <= 1'b1;
    eeprom_rx_ctl <= 16'h0000;
    @(negedge clock);
    chk({s_axi_awready, s_axi_wready, s_axi_arready}, 32'h0000_0000);
    @(posedge clock);
    eeprom_load <= 1'b0;
    enable <= 1'b1;
    @(negedge clock);
    chk(receive_frame_accept_control, 32'h0000_0a45);
    stop_test();
  end
endmodule
